// ### sd_tuning_irq_gating.v
// What this block does
// - tuning via sample-clock delay line in SDR104/HS200
// - while tuning, only buffer-read-ready may raise irq
// - send tuning command, check returned block per tap
// - crc failure sets status bit 21 only on the last tap
// - last block's crc error escapes after tuning
`timescale 1ns/1ps
`default_nettype none
`include "sd_tuning_map.vh"
module sd_tuning_irq_gating (
  input  wire                    clk,            // 125 MHz system clock
  input  wire                    reset_n,        // async reset, active low
  input  wire [1:0]              busMode,        // current bus speed mode
  input  wire                    tuningStart,    // pulse: begin tuning
  input  wire                    statusWrite,    // pulse: write-one-to-clear status
  input  wire [`IRQ_WIDTH-1:0]   statusWrData,   // ones clear status bits
  input  wire [`IRQ_WIDTH-1:0]   irqEnable,      // interrupt enable bits
  input  wire                    sdClk,          // card bus clock, asynchronous
  input  wire                    datIn,          // card data line 0, asynchronous
  output reg                     cmdOut,         // command line drive value
  output reg                     cmdOe,          // command line driven when high
  output reg  [`IRQ_WIDTH-1:0]   irqStatus,      // sticky interrupt status
  output reg                     irqOut,         // combined interrupt, active high
  output reg                     tuningActive,   // tuning in progress
  output reg  [`TAP_WIDTH-1:0]   tapSelect,      // sampling delay tap in use
  output reg  [`TAP_COUNT-1:0]   tapPassMap      // one bit per tap that passed
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CMD  = 6'h02;
  localparam [5:0] ST_WAIT = 6'h04;
  localparam [5:0] ST_DATA = 6'h08;
  localparam [5:0] ST_CRC  = 6'h10;
  localparam [5:0] ST_NEXT = 6'h20;

  reg  [5:0]              state_reg;        // one-hot state
  reg  [9:0]              bitCnt_reg;       // bit counter within a phase
  reg  [6:0]              crc7_reg;         // command checksum
  reg  [15:0]             rxCrc_reg;        // checksum received from card
  reg  [`CRC_IRQ_LAT-1:0] errPipe_reg;      // crc-to-status latency line
  reg                     clkS1_reg;        // card clock sync stage 1
  reg                     clkS2_reg;        // card clock sync stage 2
  reg                     clkS3_reg;        // previous synced card clock
  reg                     datS1_reg;        // data sync stage 1
  reg                     datS2_reg;        // data sync stage 2
  reg  [`TAP_COUNT-1:0]   datHist_reg;      // delay line of synced data
  reg                     blockDone;        // pulse: a tuning block arrived
  reg                     blockFail;        // pulse: that block failed
  wire [15:0]             dataCrc;          // computed block checksum

  wire riseEdge = clkS2_reg & ~clkS3_reg;                           // card clock rising
  wire fallEdge = ~clkS2_reg & clkS3_reg;                           // card clock falling
  wire sample   = datHist_reg[tapSelect];
  wire modeOk   = (busMode == `MODE_SDR104) || (busMode == `MODE_HS200);
  wire [39:0] cmdBody = {1'b0, 1'b1, `TUNE_CMD_INDEX, 32'h00000000};
  wire cmdBit   = cmdBody[6'd39 - bitCnt_reg[5:0]];                 // current body bit
  wire c7Fb     = cmdBit ^ crc7_reg[6];                             // crc7 feedback

  // ----------------------------------------
  // synchronisers and delay line
  // ----------------------------------------
  // stage 1 flops feed only stage 2; the delay line taps stage 2
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clkS1_reg <= 1'b0;
      clkS2_reg <= 1'b0;
      clkS3_reg <= 1'b0;
      datS1_reg <= 1'b1;
      datS2_reg <= 1'b1;
    end else begin
      clkS1_reg <= sdClk;
      clkS2_reg <= clkS1_reg;
      clkS3_reg <= clkS2_reg;
      datS1_reg <= datIn;
      datS2_reg <= datS1_reg;
    end
  end

  // one clk of delay per tap: 8 ns steps across one 64 ns bus period
  // each tap takes its neighbour, so no stage ever indexes below zero
  wire [`TAP_COUNT-1:0] histIn = {datHist_reg[`TAP_COUNT-2:0], datS2_reg}; // input of each tap
  genvar g;
  generate
    for (g = 0; g < `TAP_COUNT; g = g + 1) begin : gDelay
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          datHist_reg[g] <= 1'b1;
        end else begin
          datHist_reg[g] <= histIn[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // block checksum
  // ----------------------------------------
  crc16_serial uCrc (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (state_reg == ST_WAIT),
    .shiftEn ((state_reg == ST_DATA) && riseEdge),
    .bitIn   (sample),
    .crc_reg (dataCrc)
  );

  // ----------------------------------------
  // tuning sequencer
  // ----------------------------------------
  // walks every tap once, one command and one block per tap
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= ST_IDLE;
      bitCnt_reg   <= 10'h000;
      crc7_reg     <= 7'h00;
      rxCrc_reg    <= 16'h0000;
      cmdOut       <= 1'b1;
      cmdOe        <= 1'b0;
      tuningActive <= 1'b0;
      tapSelect    <= {`TAP_WIDTH{1'b0}};
      tapPassMap   <= {`TAP_COUNT{1'b0}};
      blockDone    <= 1'b0;
      blockFail    <= 1'b0;
    end else begin
      blockDone <= 1'b0;
      blockFail <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // start is ignored outside the two fast modes
          if (tuningStart && modeOk) begin
            tuningActive <= 1'b1;
            tapSelect    <= {`TAP_WIDTH{1'b0}};
            tapPassMap   <= {`TAP_COUNT{1'b0}};
            bitCnt_reg   <= 10'h000;
            crc7_reg     <= 7'h00;
            state_reg    <= ST_CMD;
          end
        end
        ST_CMD: begin
          // command bits change on the falling card clock edge
          if (fallEdge) begin
            cmdOe      <= 1'b1;
            bitCnt_reg <= bitCnt_reg + 10'h001;
            if (bitCnt_reg[5:0] < `CMD_BODY_BITS) begin
              cmdOut   <= cmdBit;
              crc7_reg <= {crc7_reg[5:0], 1'b0} ^ (c7Fb ? `CRC7_POLY : 7'h00);
            end else if (bitCnt_reg[5:0] < `CMD_FRAME_BITS - 6'h01) begin
              cmdOut   <= crc7_reg[6];
              crc7_reg <= {crc7_reg[5:0], 1'b0};
            end else if (bitCnt_reg[5:0] == `CMD_FRAME_BITS - 6'h01) begin
              cmdOut <= 1'b1; // end bit
            end else begin
              cmdOe      <= 1'b0;
              bitCnt_reg <= 10'h000;
              state_reg  <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // a silent card counts as a failed tap, not a hang
          if (riseEdge) begin
            bitCnt_reg <= bitCnt_reg + 10'h001;
            if (!sample) begin
              bitCnt_reg <= 10'h000;
              state_reg  <= ST_DATA;
            end else if (bitCnt_reg[6:0] == `START_TIMEOUT) begin
              blockFail <= 1'b1;
              state_reg <= ST_NEXT;
            end
          end
        end
        ST_DATA: begin
          if (riseEdge) begin
            bitCnt_reg <= bitCnt_reg + 10'h001;
            if (bitCnt_reg == `TUNE_BLOCK_BITS - 10'h001) begin
              bitCnt_reg <= 10'h000;
              state_reg  <= ST_CRC;
            end
          end
        end
        ST_CRC: begin
          if (riseEdge) begin
            rxCrc_reg  <= {rxCrc_reg[14:0], sample};
            bitCnt_reg <= bitCnt_reg + 10'h001;
            if (bitCnt_reg[4:0] == `CRC16_BITS - 5'h01) begin
              blockDone <= 1'b1;
              blockFail <= ({rxCrc_reg[14:0], sample} != dataCrc);
              state_reg <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          bitCnt_reg <= 10'h000;
          crc7_reg   <= 7'h00;
          tapPassMap[tapSelect] <= ~blockFail;
          if (tapSelect == `TAP_LAST) begin
            // tuning ends at once; the error pipe is still behind it
            tuningActive <= 1'b0;
            state_reg    <= ST_IDLE;
          end else begin
            tapSelect <= tapSelect + {{(`TAP_WIDTH-1){1'b0}}, 1'b1};
            state_reg <= ST_CMD;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // crc error latency
  // ----------------------------------------
  // the error reaches status after tuning end has lifted the mask
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      errPipe_reg <= {`CRC_IRQ_LAT{1'b0}};
    end else begin
      errPipe_reg <= {errPipe_reg[`CRC_IRQ_LAT-2:0], blockDone & blockFail};
    end
  end

  // ----------------------------------------
  // sticky status
  // ----------------------------------------
  wire crcErrSet = errPipe_reg[`CRC_IRQ_LAT-1] & ~tuningActive;
  integer i;
  reg [`IRQ_WIDTH-1:0] status_next; // next status value
  reg [`IRQ_WIDTH-1:0] setMask;     // bits raised this cycle

  // write one clears, write zero keeps, a set in the same cycle wins
  always @* begin
    setMask = {`IRQ_WIDTH{1'b0}};
    setMask[`BIT_BUF_RD_READY] = blockDone;  // read-ready passes during tuning
    setMask[`BIT_DATA_CRC_ERR] = crcErrSet;
    status_next = irqStatus;
    for (i = 0; i < `IRQ_WIDTH; i = i + 1) begin
      if (statusWrite && statusWrData[i]) begin
        status_next[i] = 1'b0;
      end
      if (setMask[i]) begin
        status_next[i] = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus <= `STATUS_RESET;
      irqOut    <= 1'b0;
    end else begin
      irqStatus <= status_next;
      // during tuning only read-ready may reach the line
      if (tuningActive) begin
        irqOut <= irqStatus[`BIT_BUF_RD_READY] & irqEnable[`BIT_BUF_RD_READY];
      end else begin
        irqOut <= |(irqStatus & irqEnable); // a zero enable masks the bit
      end
    end
  end
endmodule
`default_nettype wire

// ### sd_tuning_map.vh
`ifndef SD_TUNING_MAP_VH
`define SD_TUNING_MAP_VH
// ----------------------------------------
// status and enable field positions
// ----------------------------------------
`define IRQ_WIDTH        32
`define BIT_BUF_RD_READY 5
`define BIT_DATA_CRC_ERR 21
`define STATUS_RESET     32'h00000000
// ----------------------------------------
// bus modes that offer tuning
// ----------------------------------------
`define MODE_SDR104      2'h1
`define MODE_HS200       2'h2
// ----------------------------------------
// tuning command and block
// ----------------------------------------
`define TUNE_CMD_INDEX   6'h13
`define CMD_FRAME_BITS   6'h30
`define CMD_BODY_BITS    6'h28
`define TUNE_BLOCK_BITS  10'h200
`define CRC16_BITS       5'h10
`define CRC16_POLY       16'h1021
`define CRC7_POLY        7'h09
`define START_TIMEOUT    7'h40
// ----------------------------------------
// delay line and error latency
// ----------------------------------------
`define TAP_COUNT        8
`define TAP_WIDTH        3
`define TAP_LAST         3'h7
`define CRC_IRQ_LAT      4
`endif

// ### crc16_serial.v
`timescale 1ns/1ps
`default_nettype none
`include "sd_tuning_map.vh"
module crc16_serial (
  input  wire        clk,     // system clock
  input  wire        reset_n, // async reset, active low
  input  wire        clear,   // restart the checksum
  input  wire        shiftEn, // take one data bit
  input  wire        bitIn,   // data bit
  output reg  [15:0] crc_reg  // running checksum
);
  // ----------------------------------------
  // serial ccitt checksum
  // ----------------------------------------
  wire        feedBack = bitIn ^ crc_reg[15];                              // msb out xor data in
  wire [15:0] crc_next = {crc_reg[14:0], 1'b0} ^ (feedBack ? `CRC16_POLY : 16'h0000);

  // clear beats shift so a new block never inherits old bits
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_reg <= 16'h0000;
    end else if (clear) begin
      crc_reg <= 16'h0000;
    end else if (shiftEn) begin
      crc_reg <= crc_next;
    end
  end
endmodule
`default_nettype wire

// ### sd_tuning_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sd_tuning_map.vh"
// ----------------------------------------
// tuning interrupt gate checker
// ----------------------------------------
module sd_tuning_checker (
  input wire logic        clk,          // system clock
  input wire logic        reset_n,      // async reset, active low
  input wire logic [1:0]  busMode,      // bus speed mode
  input wire logic        tuningStart,  // start pulse
  input wire logic        statusWrite,  // clear strobe
  input wire logic [31:0] statusWrData, // clear mask
  input wire logic [31:0] irqEnable,    // enables
  input wire logic        cmdOut,       // command value
  input wire logic        cmdOe,        // command drive
  input wire logic [31:0] irqStatus,    // sticky status
  input wire logic        irqOut,       // combined interrupt
  input wire logic        tuningActive, // tuning flag
  input wire logic [2:0]  tapSelect,    // tap in use
  input wire logic [7:0]  tapPassMap    // taps that passed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // start in a mode that offers tuning
  sequence startReq;
    tuningStart && !tuningActive && (busMode == `MODE_SDR104 || busMode == `MODE_HS200);
  endsequence
  // start in any other mode, must be ignored
  sequence badStart;
    tuningStart && !tuningActive && busMode != `MODE_SDR104 && busMode != `MODE_HS200;
  endsequence
  // tuning ends with the last tap failed
  sequence lastTapFail;
    $fell(tuningActive) ##0 !tapPassMap[7];
  endsequence
  a_start_taken: assert property (startReq |=> tuningActive) else $error("tuning did not start");
  a_mode_refused: assert property (badStart |=> !tuningActive) else $error("start taken in bad mode");
  a_cmd_in_tuning: assert property (cmdOe |-> tuningActive) else $error("command line driven when idle");
  a_unused_bits: assert property ((irqStatus & ~32'h00200020) == 32'h00000000) else $error("stray status bit");
  a_crc_held_off: assert property ($rose(irqStatus[21]) |-> !$past(tuningActive)) else $error("crc flag in tuning");
  a_late_crc_set: assert property (lastTapFail |-> ##[0:8] irqStatus[21]) else $error("late crc flag missing");
  a_crc_sticky: assert property (irqStatus[21] && !(statusWrite && statusWrData[21]) |=> irqStatus[21])
    else $error("crc flag lost");
  a_irq_gated: assert property ($past(tuningActive) |-> irqOut == $past(irqStatus[5] & irqEnable[5]))
    else $error("irq leaked in tuning");
  a_irq_open: assert property (!$past(tuningActive) |-> irqOut == |$past(irqStatus & irqEnable))
    else $error("irq not enable-gated");
  a_tap_frozen: assert property (!tuningActive && !tuningStart |=> $stable(tapSelect)) else $error("tap moved");
endmodule
bind sd_tuning_irq_gating sd_tuning_checker chk_u (.clk, .reset_n, .busMode, .tuningStart, .statusWrite,
  .statusWrData, .irqEnable, .cmdOut, .cmdOe, .irqStatus, .irqOut, .tuningActive, .tapSelect, .tapPassMap);
`default_nettype wire

// ### sd_card_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sd_tuning_map.vh"
// ----------------------------------------
// card answering tuning commands
// ----------------------------------------
module sd_card_model (
  input  wire logic        clk,     // paces the card clock
  input  wire logic        run,     // card clock runs while high
  input  wire logic [7:0]  badMask, // taps whose block gets a bad crc
  input  wire logic        cmdOut,  // host command value
  input  wire logic        cmdOe,   // host command drive
  output var  logic        sdClk,   // card clock, 64 ns period
  output var  logic        datIn,   // data line, pulled up when idle
  output var  logic [47:0] lastCmd  // last command frame seen
);
  logic [1:0]  phase;  // clk count within a half period
  logic [2:0]  tapIdx; // tap of the next block
  logic [15:0] crc;    // running block checksum
  logic        fb;     // checksum feedback bit
  integer      i;      // bit counter
  initial begin
    sdClk = 1'b1;
    datIn = 1'b1;
    lastCmd = 48'h000000000000;
    phase = 2'h0;
    tapIdx = 3'h0;
  end
  // clock stands still outside tuning runs; 3 ns skew keeps edges off clk edges
  always @(posedge clk) begin
    phase <= run ? phase + 2'h1 : 2'h0;
    if (run && phase == 2'h3) begin
      sdClk <= #3 ~sdClk;
    end
  end
  // collect one command, answer with one tuning block
  always begin
    @(posedge sdClk);
    while (!(cmdOe === 1'b1 && cmdOut === 1'b0)) begin
      @(posedge sdClk);
    end
    lastCmd = 48'h000000000000;
    for (i = 0; i < 47; i = i + 1) begin
      @(posedge sdClk);
      lastCmd = {lastCmd[46:0], cmdOut};
    end
    repeat (2) @(negedge sdClk);
    datIn = 1'b0;
    crc = 16'h0000;
    for (i = 0; i < `TUNE_BLOCK_BITS; i = i + 1) begin
      @(negedge sdClk);
      datIn = i[2];
      fb = i[2] ^ crc[15];
      crc = {crc[14:0], 1'b0} ^ (fb ? `CRC16_POLY : 16'h0000);
    end
    // corrupt only the taps the bench asked for
    crc[0] = crc[0] ^ badMask[tapIdx];
    for (i = 15; i >= 0; i = i - 1) begin
      @(negedge sdClk);
      datIn = crc[i];
    end
    @(negedge sdClk);
    datIn = 1'b1;
    tapIdx = tapIdx + 3'h1;
  end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sd_tuning_map.vh"
module testbench;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        clk, reset_n, tuningStart, statusWrite, exp21;
  logic [1:0]  busMode;      // bus speed mode
  logic [31:0] statusWrData; // clear mask
  logic [31:0] irqEnable;    // interrupt enables
  logic [31:0] expStat;      // expected status
  logic [7:0]  badMask;      // taps given a bad crc
  logic [7:0]  expMap;       // expected pass map
  wire logic        sdClk, datIn, cmdOut, cmdOe, irqOut, tuningActive;
  wire logic [31:0] irqStatus;
  wire logic [2:0]  tapSelect;
  wire logic [7:0]  tapPassMap;
  wire logic [47:0] lastCmd;
  integer n_fail = 0;
  integer num_checks = 0;
  integer r, k;
  // mode, bad taps, enables, expected map, expected crc flag
  logic [50:0] rows [0:1] = '{{2'h1, 8'h81, 32'h00200000, 8'h7E, 1'b1}, {2'h2, 8'h7F, 32'h00000020, 8'h80, 1'b0}};
  sd_tuning_irq_gating dut_u (.clk, .reset_n, .busMode, .tuningStart, .statusWrite, .statusWrData, .irqEnable,
    .sdClk, .datIn, .cmdOut, .cmdOe, .irqStatus, .irqOut, .tuningActive, .tapSelect, .tapPassMap);
  sd_card_model card_u (.clk, .run(tuningActive), .badMask, .cmdOut, .cmdOe, .sdClk, .datIn, .lastCmd);
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // command checksum worked out from the frame body alone
  function automatic logic [6:0] crc7_of(input logic [39:0] body);
    logic [6:0] c;
    integer     b;
    c = 7'h00;
    for (b = 39; b >= 0; b = b - 1) begin
      c = {c[5:0], 1'b0} ^ ((body[b] ^ c[6]) ? `CRC7_POLY : 7'h00);
    end
    return c;
  endfunction
  // one-cycle start pulse, driven on falling edges
  task automatic pulse_start;
    @(negedge clk) tuningStart = 1'b1;
    @(negedge clk) tuningStart = 1'b0;
  endtask
  // software write-one-to-clear, then let status settle
  task automatic write_status(input logic [31:0] d);
    @(negedge clk) {statusWrite, statusWrData} = {1'b1, d};
    @(negedge clk) statusWrite = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog: two tuning runs take about 600 us
  initial begin
    #750000;
    n_fail = n_fail + 1;
    close_out();
  end
  initial begin
    {reset_n, busMode, tuningStart, statusWrite, statusWrData, irqEnable, badMask} = 0;
    repeat (6) @(negedge clk);
    check({cmdOut, cmdOe, irqOut, tuningActive, tapSelect, tapPassMap, irqStatus}, {4'h8, 11'h000, 32'h0});
    reset_n = 1'b1;
    $display("test reset done");
    for (r = 0; r < 2; r = r + 1) begin
      {busMode, badMask, irqEnable, expMap, exp21} = rows[r];
      expStat = {10'h000, exp21, 15'h0000, 1'b1, 5'h00}; // every arriving block raises read-ready
      pulse_start();
      check(tuningActive, 1'b1);
      // bounded wait for the eight taps to finish
      for (k = 0; k < 45000 && tuningActive !== 1'b0; k = k + 1) @(negedge clk);
      check(tuningActive, 1'b0);
      repeat (12) @(negedge clk);
      check(lastCmd, {2'h1, `TUNE_CMD_INDEX, 32'h0, crc7_of({2'h1, `TUNE_CMD_INDEX, 32'h0}), 1'b1});
      check({tapSelect, tapPassMap}, {`TAP_LAST, expMap});
      check(irqStatus, expStat);
      check(irqOut, |(expStat & irqEnable));
      @(negedge clk) irqEnable = 32'h00000000;
      repeat (3) @(negedge clk);
      check(irqOut, 1'b0);
      write_status(32'h00000000);
      check(irqStatus, expStat);
      write_status(32'hFFFFFFFF);
      check(irqStatus, 32'h00000000);
      $display("test row %0d done", r);
    end
    // modes without tuning ignore the start pulse
    for (r = 0; r < 4; r = r + 3) begin
      busMode = r[1:0];
      pulse_start();
      check(tuningActive, 1'b0);
    end
    $display("test refused modes done");
    close_out();
  end
endmodule
`default_nettype wire
